//--- hdl/ivm_consts.vh
// Purpose: shared constants of the interrupt vector mapper
// Assumes: 20-bit (1 Mbyte) address space, byte-wide vector reads
// Notes: definitions only
`ifndef IVM_CONSTS_VH
`define IVM_CONSTS_VH

// widths
`define IVM_ADDR_W 20
`define IVM_N_SRC 32
`define IVM_LVL_W 3
`define IVM_IDX_W 5
`define IVM_SWI_W 6

// fixed vector region, top of the address space
`define IVM_FIX_LO 20'hFFFDC
`define IVM_FIX_HI 20'hFFFFF
`define IVM_VEC_UND 20'hFFFDC
`define IVM_VEC_OVF 20'hFFFE0
`define IVM_VEC_BRK 20'hFFFE4
`define IVM_VEC_AMATCH 20'hFFFE8
`define IVM_VEC_SSTEP 20'hFFFEC
`define IVM_VEC_WDT 20'hFFFF0
`define IVM_VEC_DBG 20'hFFFF4
`define IVM_VEC_RSVD 20'hFFFF8
`define IVM_VEC_RESET 20'hFFFFC

// vector entry layout: four bytes, low byte first
`define IVM_LAST_BYTE 2'h3
`define IVM_ENTRY_SHIFT 2
`define IVM_BYTE_ONES 8'hFF
`define IVM_ADDR_ONE 20'h00001

// variable table entry numbers
`define IVM_E_BRK 6'h00
`define IVM_E_DISPLAY_UNIT_ONE 5'h04
`define IVM_E_DS1 5'h05
`define IVM_E_DISPLAY_UNIT_TWO 5'h08
`define IVM_E_I2C1 5'h09
`define IVM_E_BCOL 5'h0A
`define IVM_E_DMA0 5'h0B
`define IVM_E_DMA1 5'h0C
`define IVM_E_I2C0 5'h0D
`define IVM_E_AD 5'h0E
`define IVM_E_S2TX 5'h0F
`define IVM_E_S2RX 5'h10
`define IVM_E_S0TX 5'h11
`define IVM_E_S0RX 5'h12
`define IVM_E_DS0 5'h13
`define IVM_E_VSYNC 5'h14
`define IVM_E_TA0 5'h15
`define IVM_E_TB0 5'h1A
`define IVM_E_EXT_PIN_IRQ_ZERO 5'h1D
`define IVM_E_EXT_PIN_IRQ_ONE 5'h1E

// edge sensitivity codes
`define IVM_SENSE_RISE 2'h0
`define IVM_SENSE_FALL 2'h1
`define IVM_SENSE_BOTH 2'h2

`endif

//--- hdl/ivm_edge.v
// Purpose: edge detector for an interrupt pin
// Assumes: pin already synchronous to sys_clk
// Notes: no edge is reported in the first enabled cycle after reset
`timescale 1ns/1ns
`include "ivm_consts.vh"

module ivm_edge (
  input wire sys_clk,
  input wire arst_n,
  input wire clk_en,
  input wire [1:0] sense,
  input wire pin,
  output reg edge_hit
);

reg pin_prev; // pin level one cycle ago
reg armed; // prev holds a real sample

//////////////////////////////////////////////////////////////////////
// remember the last pin level
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    pin_prev <= 1'b0;
    armed <= 1'b0;
  end else if (clk_en) begin
    pin_prev <= pin;
    armed <= 1'b1;
  end
end

//////////////////////////////////////////////////////////////////////
// compare against the selected sensitivity
always @* begin
  edge_hit = 1'b0;
  if (armed && clk_en) begin
    case (sense)
      `IVM_SENSE_RISE: edge_hit = pin & ~pin_prev;
      `IVM_SENSE_FALL: edge_hit = ~pin & pin_prev;
      `IVM_SENSE_BOTH: edge_hit = pin ^ pin_prev;
      default: edge_hit = 1'b0; // unused code: pin ignored
    endcase
  end
end

endmodule // ivm_edge

//--- hdl/ivm_mapper.v
// Purpose: maps interrupt sources to vector slots and fetches routines
// Assumes: byte-wide vector memory port, requests synchronous to sys_clk
// Notes: starts by fetching the reset vector after reset release
//
// Operation
// - vector entry is four bytes, low first
// - fixed region FFFDC to FFFFF never moves
// - undefined, overflow, break use fixed slots
// - address match gated; watchdog, reset fixed
// - all-ones break vector falls to entry zero
// - variable address is base plus four times number
// - entry zero is break, never masked
// - entries 32 to 63 software only, unmasked
// - entries 4,5,8,9 display, slicer, two-wire
// - entries 10 to 14 collision, DMA, bus, A-D
// - entries 15 to 18 serial channels
// - slicer zero, sync, timers A0 to A4
// - timers B, external pins, entry 31 reserved
// - external pins rise, fall or both
// - active sync edge raises a request
// - two-wire bus: transfer done or STOP
// - display unit done raises a request
// - continue at routine address from vector
// - pending set by hardware, cleared on acceptance
// - accept only level above processor level
`timescale 1ns/1ns
`include "ivm_consts.vh"

module ivm_mapper (
  input wire sys_clk,
  input wire arst_n,
  input wire clk_en,
  input wire [`IVM_ADDR_W-1:0] vector_table_base,
  input wire i_flag,
  input wire [`IVM_LVL_W-1:0] cpu_ipl,
  input wire [`IVM_N_SRC*`IVM_LVL_W-1:0] src_level,
  input wire [`IVM_N_SRC-1:0] pend_clr,
  input wire undefined_opcode_trap,
  input wire overflow_trap,
  input wire break_instruction,
  input wire amatch_req,
  input wire amatch_en,
  input wire wdt_req,
  input wire swi_req,
  input wire [`IVM_SWI_W-1:0] swi_num,
  input wire display_unit_one,
  input wire display_unit_two,
  input wire slicer_zero,
  input wire slicer_one,
  input wire twi0_done,
  input wire twi0_stop,
  input wire twi1_done,
  input wire twi1_stop,
  input wire bus_collision,
  input wire dma0_done,
  input wire dma1_done,
  input wire adc_done,
  input wire serial_channel_two_tx,
  input wire serial_channel_two_rx,
  input wire serial_channel_zero_tx,
  input wire serial_channel_zero_rx,
  input wire [4:0] timer_a,
  input wire [2:0] timer_b,
  input wire ext_pin_irq_zero,
  input wire ext_pin_irq_one,
  input wire [1:0] ext_sense_zero,
  input wire [1:0] ext_sense_one,
  input wire vsync_in,
  input wire [1:0] vsync_sense,
  output wire mem_rd,
  output reg [`IVM_ADDR_W-1:0] mem_addr,
  input wire mem_ack,
  input wire [7:0] mem_rdata,
  output reg jump_valid,
  output reg [`IVM_ADDR_W-1:0] jump_pc,
  output reg [`IVM_LVL_W-1:0] jump_level,
  output reg jump_maskable,
  output wire busy,
  output reg [`IVM_N_SRC-1:0] pending
);

// state codes
localparam [1:0] S_IDLE = 2'h0;
localparam [1:0] S_READ = 2'h1;
localparam [1:0] S_CHECK = 2'h2;

reg [1:0] state; // fetch sequencer state
reg [1:0] byte_cnt; // byte of the entry being read
reg [31:0] vec_buf; // assembled vector entry
reg cur_brk_fixed; // fetching the fixed break slot
reg cur_maskable; // fetch belongs to a pending bit
reg [`IVM_IDX_W-1:0] cur_idx; // entry being served
reg [`IVM_LVL_W-1:0] cur_lvl; // level handed to the cpu
reg p_und, p_ovf, p_brk, p_am, p_wdt, p_swi; // special requests
reg [`IVM_SWI_W-1:0] swi_q; // latched software number
wire ext_pin_irq_zero_hit, ext_pin_irq_one_hit, vsync_hit; // edge events
wire pk_hit; // a maskable request wins
wire [`IVM_IDX_W-1:0] pk_idx; // winning entry
wire [`IVM_LVL_W-1:0] pk_lvl; // winning level
reg [`IVM_N_SRC-1:0] req_vec; // this cycle's source events
reg [`IVM_N_SRC-1:0] acc_clr; // accepted entry to clear

//////////////////////////////////////////////////////////////////////
// variable slot address: base plus four bytes per number
function [`IVM_ADDR_W-1:0] var_addr;
  input [`IVM_ADDR_W-1:0] base;
  input [`IVM_SWI_W-1:0] num;
  begin
    var_addr = base + ({{(`IVM_ADDR_W-`IVM_SWI_W){1'b0}}, num}
      << `IVM_ENTRY_SHIFT);
  end
endfunction

//////////////////////////////////////////////////////////////////////
// edge detectors for the pins and the sync input
ivm_edge u_ext_pin_irq_zero (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .sense(ext_sense_zero),
  .pin(ext_pin_irq_zero),
  .edge_hit(ext_pin_irq_zero_hit)
);

ivm_edge u_ext_pin_irq_one (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .sense(ext_sense_one),
  .pin(ext_pin_irq_one),
  .edge_hit(ext_pin_irq_one_hit)
);

ivm_edge u_vsync (
  .sys_clk(sys_clk),
  .arst_n(arst_n),
  .clk_en(clk_en),
  .sense(vsync_sense),
  .pin(vsync_in),
  .edge_hit(vsync_hit)
);

//////////////////////////////////////////////////////////////////////
// route each source onto its table entry
always @* begin
  req_vec = {`IVM_N_SRC{1'b0}}; // entries 1-3, 6, 7, 31 stay idle
  req_vec[`IVM_E_DISPLAY_UNIT_ONE] = display_unit_one;
  req_vec[`IVM_E_DS1] = slicer_one;
  req_vec[`IVM_E_DISPLAY_UNIT_TWO] = display_unit_two;
  req_vec[`IVM_E_I2C1] = twi1_done | twi1_stop;
  req_vec[`IVM_E_BCOL] = bus_collision;
  req_vec[`IVM_E_DMA0] = dma0_done;
  req_vec[`IVM_E_DMA1] = dma1_done;
  req_vec[`IVM_E_I2C0] = twi0_done | twi0_stop;
  req_vec[`IVM_E_AD] = adc_done;
  req_vec[`IVM_E_S2TX] = serial_channel_two_tx;
  req_vec[`IVM_E_S2RX] = serial_channel_two_rx;
  req_vec[`IVM_E_S0TX] = serial_channel_zero_tx;
  req_vec[`IVM_E_S0RX] = serial_channel_zero_rx;
  req_vec[`IVM_E_DS0] = slicer_zero;
  req_vec[`IVM_E_VSYNC] = vsync_hit;
  req_vec[`IVM_E_TA0 +: 5] = timer_a;
  req_vec[`IVM_E_TB0 +: 3] = timer_b;
  req_vec[`IVM_E_EXT_PIN_IRQ_ZERO] = ext_pin_irq_zero_hit;
  req_vec[`IVM_E_EXT_PIN_IRQ_ONE] = ext_pin_irq_one_hit;
end

//////////////////////////////////////////////////////////////////////
// maskable arbitration against the processor level
ivm_pick #(
  .N_SRC(`IVM_N_SRC)
) u_pick (
  .pend(pending),
  .levels(src_level),
  .cpu_ipl(cpu_ipl),
  .i_flag(i_flag),
  .hit(pk_hit),
  .idx(pk_idx),
  .lvl(pk_lvl)
);

//////////////////////////////////////////////////////////////////////
// clear mask for the entry whose vector has just been taken
always @* begin
  acc_clr = {`IVM_N_SRC{1'b0}};
  if (state == S_CHECK && cur_maskable && !(cur_brk_fixed &&
      vec_buf == {4{`IVM_BYTE_ONES}}))
    acc_clr[cur_idx] = 1'b1;
end

//////////////////////////////////////////////////////////////////////
// pending bits: a new event beats any clear in the same cycle
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    pending <= {`IVM_N_SRC{1'b0}};
  end else if (clk_en) begin
    pending <= (pending & ~pend_clr & ~acc_clr) | req_vec;
  end
end

// handshake outputs
assign mem_rd = (state == S_READ);
assign busy = (state != S_IDLE);

//////////////////////////////////////////////////////////////////////
// fetch sequencer, special request latches and cpu hand-off
always @(posedge sys_clk or negedge arst_n) begin
  if (!arst_n) begin
    state <= S_READ; // boot: fetch the reset vector
    mem_addr <= `IVM_VEC_RESET;
    byte_cnt <= 2'h0;
    vec_buf <= 32'h00000000;
    cur_brk_fixed <= 1'b0;
    cur_maskable <= 1'b0;
    cur_idx <= {`IVM_IDX_W{1'b0}};
    cur_lvl <= {`IVM_LVL_W{1'b0}};
    p_und <= 1'b0;
    p_ovf <= 1'b0;
    p_brk <= 1'b0;
    p_am <= 1'b0;
    p_wdt <= 1'b0;
    p_swi <= 1'b0;
    swi_q <= {`IVM_SWI_W{1'b0}};
    jump_valid <= 1'b0;
    jump_pc <= {`IVM_ADDR_W{1'b0}};
    jump_level <= {`IVM_LVL_W{1'b0}};
    jump_maskable <= 1'b0;
  end else if (clk_en) begin
    jump_valid <= 1'b0;
    // special requests latch; a fresh request wins over the take, except a software request, which is ignored while p_swi is set
    if (undefined_opcode_trap)
      p_und <= 1'b1;
    if (overflow_trap)
      p_ovf <= 1'b1;
    if (break_instruction)
      p_brk <= 1'b1;
    if (amatch_req && amatch_en)
      p_am <= 1'b1; // only while the match is enabled
    if (wdt_req)
      p_wdt <= 1'b1;
    if (swi_req && !p_swi) begin
      p_swi <= 1'b1;
      swi_q <= swi_num;
    end
    case (state)
      S_IDLE: begin
        byte_cnt <= 2'h0;
        cur_brk_fixed <= 1'b0;
        cur_maskable <= 1'b0;
        cur_lvl <= {`IVM_LVL_W{1'b0}};
        // single-step, debugger and reserved slots have no path
        if (p_wdt) begin
          state <= S_READ;
          mem_addr <= `IVM_VEC_WDT;
          p_wdt <= wdt_req;
        end else if (p_am) begin
          state <= S_READ;
          mem_addr <= `IVM_VEC_AMATCH;
          p_am <= amatch_req && amatch_en;
        end else if (p_und) begin
          state <= S_READ;
          mem_addr <= `IVM_VEC_UND;
          p_und <= undefined_opcode_trap;
        end else if (p_ovf) begin
          state <= S_READ;
          mem_addr <= `IVM_VEC_OVF;
          p_ovf <= overflow_trap;
        end else if (p_brk) begin
          state <= S_READ;
          mem_addr <= `IVM_VEC_BRK;
          cur_brk_fixed <= 1'b1;
          p_brk <= break_instruction;
        end else if (p_swi) begin
          // any number, zero and 32-63 included, ignores the flag
          state <= S_READ;
          mem_addr <= var_addr(vector_table_base, swi_q);
          p_swi <= 1'b0;
        end else if (pk_hit) begin
          state <= S_READ;
          mem_addr <= var_addr(vector_table_base,
            {1'b0, pk_idx});
          cur_maskable <= 1'b1;
          cur_idx <= pk_idx;
          cur_lvl <= pk_lvl;
        end
      end
      S_READ: begin
        if (mem_ack) begin
          // low byte lands first, then upward
          vec_buf[byte_cnt*8 +: 8] <= mem_rdata;
          if (byte_cnt == `IVM_LAST_BYTE) begin
            state <= S_CHECK;
          end else begin
            byte_cnt <= byte_cnt + 2'h1;
            mem_addr <= mem_addr + `IVM_ADDR_ONE;
          end
        end
      end
      S_CHECK: begin
        if (cur_brk_fixed && vec_buf == {4{`IVM_BYTE_ONES}}) begin
          // unprogrammed break slot: use variable entry zero
          state <= S_READ;
          mem_addr <= var_addr(vector_table_base, `IVM_E_BRK);
          byte_cnt <= 2'h0;
          cur_brk_fixed <= 1'b0;
        end else begin
          // hand the routine start to the cpu
          state <= S_IDLE;
          jump_valid <= 1'b1;
          jump_pc <= vec_buf[`IVM_ADDR_W-1:0];
          jump_level <= cur_lvl;
          jump_maskable <= cur_maskable;
        end
      end
      default: begin
        state <= S_IDLE;
      end
    endcase
  end
end

endmodule // ivm_mapper

//--- hdl/ivm_pick.v
// Purpose: choose the maskable request to accept
// Assumes: one level field per table entry
// Notes: ties go to the lowest entry number
`timescale 1ns/1ns
`include "ivm_consts.vh"

module ivm_pick #(
  parameter N_SRC = `IVM_N_SRC
) (
  input wire [N_SRC-1:0] pend,
  input wire [N_SRC*`IVM_LVL_W-1:0] levels,
  input wire [`IVM_LVL_W-1:0] cpu_ipl,
  input wire i_flag,
  output reg hit,
  output reg [`IVM_IDX_W-1:0] idx,
  output reg [`IVM_LVL_W-1:0] lvl
);

integer i;
reg [`IVM_LVL_W-1:0] cand; // level of entry i

//////////////////////////////////////////////////////////////////////
// scan all entries; a level must beat the current best strictly
always @* begin
  hit = 1'b0;
  idx = {`IVM_IDX_W{1'b0}};
  lvl = cpu_ipl;
  cand = {`IVM_LVL_W{1'b0}};
  for (i = 0; i < N_SRC; i = i + 1) begin
    cand = levels[i*`IVM_LVL_W +: `IVM_LVL_W];
    if (i_flag && pend[i] && cand > lvl) begin
      hit = 1'b1;
      idx = i[`IVM_IDX_W-1:0];
      lvl = cand;
    end
  end
end

endmodule // ivm_pick

//--- testbench/ivm_mapper_sva.sv
// Purpose: port checker of the interrupt vector mapper
// Assumes: single clock domain, asynchronous low reset
// Notes: bound to the top module below
`timescale 1ns/1ns
module ivm_mapper_sva (
  input wire sys_clk,
  input wire arst_n,
  input wire clk_en,
  input wire [2:0] cpu_ipl,
  input wire [4:0] timer_a,
  input wire [31:0] pend_clr,
  input wire mem_rd,
  input wire [19:0] mem_addr,
  input wire mem_ack,
  input wire jump_valid,
  input wire [2:0] jump_level,
  input wire jump_maskable,
  input wire busy,
  input wire [31:0] pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////
  sequence s_ack; clk_en && mem_rd && mem_ack; endsequence
  sequence s_wait; clk_en && mem_rd && !mem_ack; endsequence
  property p_addr_step; s_ack ##1 mem_rd |-> mem_addr == $past(mem_addr) + 20'h00001; endproperty
  a_addr_step: assert property (p_addr_step) else $error("fetch address no step");
  property p_hold; s_wait |=> mem_rd && $stable(mem_addr); endproperty
  a_hold: assert property (p_hold) else $error("fetch request not held");
  property p_no_dbg;
    mem_rd |-> !(mem_addr inside {[20'hFFFEC:20'hFFFEF], [20'hFFFF4:20'hFFFFB]});
  endproperty
  a_no_dbg: assert property (p_no_dbg) else $error("debug slot fetched");
  property p_jump_after; jump_valid |-> $past(mem_rd && mem_ack, 2) && !$past(mem_rd); endproperty
  a_jump_after: assert property (p_jump_after) else $error("jump not after fetch");
  property p_jump_pulse; jump_valid |=> !jump_valid; endproperty
  a_jump_pulse: assert property (p_jump_pulse) else $error("jump longer than a cycle");
  property p_level; jump_valid && jump_maskable |-> jump_level > cpu_ipl; endproperty
  a_level: assert property (p_level) else $error("level not above processor");
  property p_idle; $fell(busy) |-> jump_valid; endproperty
  a_idle: assert property (p_idle) else $error("idle without jump");
  property p_pend_set; clk_en && timer_a[0] |=> pending[21]; endproperty
  a_pend_set: assert property (p_pend_set) else $error("pending not set");
  property p_pend_clr; $fell(pending[21]) |-> jump_valid || $past(pend_clr[21]); endproperty
  a_pend_clr: assert property (p_pend_clr) else $error("pending cleared early");
endmodule // ivm_mapper_sva
bind ivm_mapper ivm_mapper_sva u_ivm_mapper_sva (.sys_clk(sys_clk), .arst_n(arst_n),
  .clk_en(clk_en), .cpu_ipl(cpu_ipl), .timer_a(timer_a), .pend_clr(pend_clr), .mem_rd(mem_rd),
  .mem_addr(mem_addr), .mem_ack(mem_ack), .jump_valid(jump_valid), .jump_level(jump_level),
  .jump_maskable(jump_maskable), .busy(busy), .pending(pending));

//--- testbench/ivm_vmem.sv
// Purpose: vector memory at the far side of the fetch port
// Assumes: one byte per read, ack given combinationally while ready
// Notes: slow mode answers every other cycle
`timescale 1ns/1ns
module ivm_vmem (
  input wire sys_clk,
  input wire arst_n,
  input wire slow,
  input wire brk_ones,
  input wire mem_rd,
  input wire [19:0] mem_addr,
  output wire mem_ack,
  output wire [7:0] mem_rdata
);
  reg ready; // answer gate
  wire [7:0] byte_val; // stored byte at the address
  // break slot may hold all ones, else a pattern of the address, low byte first
  assign byte_val = (brk_ones && mem_addr[19:2] == 18'h3FFF9) ? 8'hFF :
    mem_addr[7:0] ^ 8'hA5;
  // ready toggles in slow mode to stretch each byte
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) ready <= 1'b0;
    else ready <= slow ? ~ready : 1'b1;
  end
  assign mem_ack = mem_rd & ready;
  // no answer: drive the inverse so a stale byte never matches
  assign mem_rdata = mem_ack ? byte_val : ~byte_val;
endmodule // ivm_vmem

//--- testbench/test_interrupt_vector_mapper.sv
// Purpose: self-checking bench of the interrupt vector mapper
// Assumes: vector memory model answers every read
// Notes: peripheral sources run from a row table, special cases follow
`timescale 1ns/1ns
module test_interrupt_vector_mapper;
  logic sys_clk = 0, arst_n = 0, clk_en = 1, i_flag = 1, slow = 0, brk_ones = 0;
  logic amatch_en = 1, swi_req = 0, ext_pin_irq_zero = 0, ext_pin_irq_one = 0, vsync_in = 0;
  logic [2:0] cpu_ipl = 0;
  logic [5:0] swi_num = 0;
  logic [1:0] ext_sense_zero = 0, ext_sense_one = 0, vsync_sense = 0;
  logic [95:0] src_level = {32{3'h3}}; // every entry at level 3
  logic [31:0] pend_clr = 0, ev = 0; // ev: one bit per event input
  logic [19:0] vector_table_base = 20'h0F00D; // odd base shows an add, not an or
  wire undefined_opcode_trap = ev[0], overflow_trap = ev[1], break_instruction = ev[2];
  wire amatch_req = ev[3], wdt_req = ev[31];
  wire display_unit_one = ev[4], slicer_one = ev[5], twi0_stop = ev[6], twi1_stop = ev[7];
  wire display_unit_two = ev[8], twi1_done = ev[9], bus_collision = ev[10], dma0_done = ev[11];
  wire dma1_done = ev[12], twi0_done = ev[13], adc_done = ev[14], slicer_zero = ev[19];
  wire serial_channel_two_tx = ev[15], serial_channel_two_rx = ev[16];
  wire serial_channel_zero_tx = ev[17], serial_channel_zero_rx = ev[18];
  wire [4:0] timer_a = ev[25:21];
  wire [2:0] timer_b = ev[28:26];
  wire mem_rd, mem_ack, jump_valid, jump_maskable, busy;
  wire [7:0] mem_rdata;
  wire [19:0] mem_addr, jump_pc;
  wire [2:0] jump_level;
  wire [31:0] pending;
  int num_errors = 0, total_checks = 0;
  // rows: {event bit, entry}
  localparam logic [9:0] rows [24] = '{10'h084, 10'h0A5, 10'h108, 10'h129, 10'h0E9, 10'h14A,
    10'h16B, 10'h18C, 10'h1AD, 10'h0CD, 10'h1CE, 10'h1EF, 10'h210, 10'h231, 10'h252, 10'h273,
    10'h2B5, 10'h2D6, 10'h2F7, 10'h318, 10'h339, 10'h35A, 10'h37B, 10'h39C};
  // fixed slots: {event bit, vector}, no debug or reserved slot requested
  localparam logic [24:0] fix [5] = '{{5'h00, 20'hFFFDC}, {5'h01, 20'hFFFE0},
    {5'h02, 20'hFFFE4}, {5'h03, 20'hFFFE8}, {5'h1F, 20'hFFFF0}};
  ivm_mapper u_ivm_mapper (.*);
  ivm_vmem u_ivm_vmem (.sys_clk(sys_clk), .arst_n(arst_n), .slow(slow), .brk_ones(brk_ones),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  always #25 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////
  function automatic logic [19:0] epc(input logic [19:0] a);
    logic [23:0] w;
    w = {a[7:0] + 8'h02 ^ 8'hA5, a[7:0] + 8'h01 ^ 8'hA5, a[7:0] ^ 8'hA5};
    return w[19:0];
  endfunction
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // one-cycle event pulse on the rising edge
  task automatic pulse(input int b);
    @(posedge sys_clk) ev <= 32'h1 << b;
    @(posedge sys_clk) ev <= 0;
  endtask
  // bounded wait for a jump; lvl is {maskable, level}
  task automatic expect_jump(input logic want, input logic [19:0] a, input logic [3:0] lvl);
    logic seen;
    seen = 0;
    for (int i = 0; i < 40 && !seen; i++) begin
      @(posedge sys_clk);
      #1 seen = jump_valid;
    end
    check("jump seen", seen, want);
    if (seen && want) begin
      check("jump_pc", jump_pc, epc(a));
      check("jump_level", {jump_maskable, jump_level}, lvl);
    end
    if (want && !seen) finish_test();
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge sys_clk);
    check("reset addr", mem_addr, 20'hFFFFC);
    check("reset busy", busy, 1);
    check("reset pending", pending, 0);
    arst_n <= 1;
    expect_jump(1, 20'hFFFFC, 4'h0);
    $display("test reset done");
    // peripheral rows, memory slow on rows with an odd entry number
    for (int i = 0; i < 24; i++) begin
      @(posedge sys_clk) slow <= rows[i][0];
      pulse(rows[i][9:5]);
      expect_jump(1, vector_table_base + {rows[i][4:0], 2'h0}, 4'hB);
      check("pending cleared", pending[rows[i][4:0]], 0);
      $display("test row %0d done", i);
    end
    @(posedge sys_clk) src_level[68:66] <= 3'h0;
    pulse(22);
    expect_jump(0, 0, 0);
    @(posedge sys_clk) i_flag <= 0;
    for (int i = 0; i < 5; i++) begin
      pulse(fix[i][24:20]);
      expect_jump(1, fix[i][19:0], 4'h0);
    end
    @(posedge sys_clk) amatch_en <= 0;
    pulse(3);
    expect_jump(0, 0, 0);
    @(posedge sys_clk) brk_ones <= 1;
    pulse(2);
    expect_jump(1, vector_table_base, 4'h0);
    $display("test fixed done");
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk) swi_req <= 1;
      swi_num <= i ? 6'h3F : 6'h20;
      @(posedge sys_clk) swi_req <= 0;
      expect_jump(1, vector_table_base + (i ? 20'h000FC : 20'h00080), 4'h0);
    end
    pulse(26);
    #1 check("pending set", pending[26], 1);
    @(posedge sys_clk) pend_clr <= 32'h1 << 26;
    @(posedge sys_clk) pend_clr <= 0;
    #1 check("pending software clear", pending[26], 0);
    pulse(21);
    expect_jump(0, 0, 0);
    check("pending held", pending[21], 1);
    @(posedge sys_clk) i_flag <= 1;
    cpu_ipl <= 3'h3;
    expect_jump(0, 0, 0);
    @(posedge sys_clk) cpu_ipl <= 3'h2;
    expect_jump(1, vector_table_base + 20'h00054, 4'hB);
    $display("test masking done");
    for (int c = 0; c < 3; c++) begin
      @(posedge sys_clk) ext_sense_zero <= c[1:0];
      @(posedge sys_clk) ext_pin_irq_zero <= 1;
      expect_jump(c != 1, vector_table_base + 20'h00074, 4'hB);
      @(posedge sys_clk) ext_pin_irq_zero <= 0;
      expect_jump(c != 0, vector_table_base + 20'h00074, 4'hB);
    end
    @(posedge sys_clk) ext_pin_irq_one <= 1;
    expect_jump(1, vector_table_base + 20'h00078, 4'hB);
    @(posedge sys_clk) vsync_in <= 1;
    expect_jump(1, vector_table_base + 20'h00050, 4'hB);
    $display("test edges done");
    // freeze: an event while the enable is low is lost; sense code 3 ignores the pin
    @(posedge sys_clk) clk_en <= 0;
    ext_sense_one <= 2'h3;
    pulse(23);
    #1 check("frozen pending", pending[23], 0);
    @(posedge sys_clk) clk_en <= 1;
    ext_pin_irq_one <= 0;
    expect_jump(0, 0, 0);
    check("pending after freeze", pending[23], 0);
    $display("test freeze done");
    finish_test();
  end
endmodule // test_interrupt_vector_mapper
